// *** hdl/gwc_config.sv ***
// Serial master settings and DIP address decode of the gateway
// Assumes an APB master on pclk and a raw asynchronous DIP switch bus
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module gwc_config #(
    parameter int FLASH_CYC = gwc_pkg::FLASH_CYC
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial master side
    input  wire logic        frame_idle,
    output logic      [7:0]  master_slave_id,
    output logic      [1:0]  master_baud_sel,
    output logic      [1:0]  master_parity_sel,
    output logic      [1:0]  master_stop_bits,
    // Switches and address outputs
    input  wire logic [7:0]  dip_switch_n,
    output logic             use_nv_ip,
    output logic      [31:0] ip_addr,
    output logic      [31:0] ip_mask,
    output logic      [31:0] ip_gateway,
    output logic             startup_ok,
    output logic             power_indicator_led,
    output logic             gateway_indicator_led
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  slave_id;
        logic [7:0]  baud;
        logic [7:0]  parity;
        logic [1:0]  act_baud;
        logic [1:0]  act_parity;
        logic [7:0]  dip_s1;
        logic [7:0]  dip_s2;
        logic [31:0] rdata;
        logic [31:0] flash_cnt;
        logic        flash;
    } gwc_state_s;

    gwc_state_s st_q;
    gwc_state_s st_d;
    logic [11:0] idx;
    logic        acc;
    logic        wr_ok;
    logic [7:0]  wval;
    logic [7:0]  sw;
    logic        sw_bad;

    assign idx  = paddr[13:2];
    assign acc  = psel && penable;
    assign wval = pwdata[7:0];
    assign sw   = st_q.dip_s2;
    assign sw_bad = (sw == gwc_pkg::SW_INVALID);
    assign wr_ok = acc && pwrite && pstrb[0];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Two-stage switch synchroniser; closed position reads as one
        st_d.dip_s1 = ~dip_switch_n;
        st_d.dip_s2 = st_q.dip_s1;
        // Range-checked writes, applied at once
        if (wr_ok && idx == gwc_pkg::IDX_SLAVE_ID &&
            wval >= gwc_pkg::SLAVE_ID_MIN && wval <= gwc_pkg::SLAVE_ID_MAX) begin
            st_d.slave_id = wval;
        end
        if (wr_ok && idx == gwc_pkg::IDX_BAUD && wval <= gwc_pkg::BAUD_MAX) begin
            st_d.baud = wval;
        end
        if (wr_ok && idx == gwc_pkg::IDX_PARITY && wval <= gwc_pkg::PARITY_MAX) begin
            st_d.parity = wval;
        end
        // Line settings follow only between frames
        if (frame_idle) begin
            st_d.act_baud   = st_q.baud[1:0];
            st_d.act_parity = st_q.parity[1:0];
        end
        // Read data captured in setup phase
        if (psel && !penable && !pwrite) begin
            case (idx)
                gwc_pkg::IDX_SLAVE_ID: st_d.rdata = {24'h00_0000, st_q.slave_id};
                gwc_pkg::IDX_BAUD:     st_d.rdata = {24'h00_0000, st_q.baud};
                gwc_pkg::IDX_PARITY:   st_d.rdata = {24'h00_0000, st_q.parity};
                gwc_pkg::IDX_STATUS:   st_d.rdata = {22'h00_0000, sw_bad, use_nv_ip, sw};
                gwc_pkg::IDX_IP_ADDR:  st_d.rdata = ip_addr;
                gwc_pkg::IDX_IP_MASK:  st_d.rdata = ip_mask;
                gwc_pkg::IDX_IP_GW:    st_d.rdata = ip_gateway;
                default:               st_d.rdata = 32'h0000_0000;
            endcase
        end
        // Flash timer for the invalid-address indication
        if (st_q.flash_cnt >= 32'(FLASH_CYC - 1)) begin
            st_d.flash_cnt = 32'h0000_0000;
            st_d.flash     = ~st_q.flash;
        end else begin
            st_d.flash_cnt = st_q.flash_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Registers, volatile defaults at reset
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{slave_id: gwc_pkg::RST_SLAVE_ID, baud: gwc_pkg::RST_BAUD,
                      parity: gwc_pkg::RST_PARITY, act_baud: gwc_pkg::RST_BAUD[1:0],
                      act_parity: gwc_pkg::RST_PARITY[1:0], default: '0};
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Master-side settings only; nothing addresses the slave's setup
    assign master_slave_id   = st_q.slave_id;
    assign master_baud_sel   = st_q.act_baud;
    assign master_parity_sel = st_q.act_parity;
    assign master_stop_bits  = gwc_pkg::STOP_BITS;
    assign prdata  = st_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Address decode from the switch sum
    always_comb begin
        use_nv_ip  = (sw == 8'h00);
        ip_mask    = use_nv_ip ? 32'h0000_0000 : gwc_pkg::IP_MASK;
        ip_addr    = use_nv_ip ? 32'h0000_0000 : {gwc_pkg::IP_PREFIX, sw};
        if (sw == gwc_pkg::SW_FIXED) begin
            ip_gateway = {gwc_pkg::IP_PREFIX, gwc_pkg::GW_OCT_FIXED};
        end else if (use_nv_ip || sw_bad) begin
            ip_gateway = 32'h0000_0000;
        end else begin
            ip_gateway = {gwc_pkg::IP_PREFIX, gwc_pkg::GW_OCT_RANGE};
        end
        if (sw_bad) begin
            ip_addr = 32'h0000_0000;
            ip_mask = 32'h0000_0000;
        end
    end

    // Invalid setting halts start-up and flashes both leds
    assign startup_ok            = !sw_bad;
    assign power_indicator_led   = sw_bad && st_q.flash;
    assign gateway_indicator_led = sw_bad && st_q.flash;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_range_id;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_ok && idx == gwc_pkg::IDX_SLAVE_ID && (wval == 8'h00 || wval > 8'hf7))
        |=> $stable(master_slave_id);
    endproperty
    a_range_id: assert property (p_range_id) else $error("illegal id stored");

    property p_legal_id;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_ok && idx == gwc_pkg::IDX_SLAVE_ID && wval >= 8'h01 && wval <= 8'hf7)
        |=> master_slave_id == $past(wval);
    endproperty
    a_legal_id: assert property (p_legal_id) else $error("legal id not applied");

    property p_baud_busy;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !frame_idle) |=> $stable(master_baud_sel) && $stable(master_parity_sel);
    endproperty
    a_baud_busy: assert property (p_baud_busy) else $error("line change mid frame");

    property p_ranges;
        @(posedge pclk) disable iff (!presetn)
        st_q.baud <= 8'h03 && st_q.parity <= 8'h02 && master_slave_id != 8'h00;
    endproperty
    a_ranges: assert property (p_ranges) else $error("setting out of range");

    property p_stop;
        @(posedge pclk) disable iff (!presetn) master_stop_bits == 2'h1;
    endproperty
    a_stop: assert property (p_stop) else $error("stop bits not one");

    property p_fixed;
        @(posedge pclk) disable iff (!presetn)
        sw == 8'h01 |-> ip_addr == 32'hc0a8_0101 && ip_gateway == 32'hc0a8_0102;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed address wrong");

    property p_range_ip;
        @(posedge pclk) disable iff (!presetn)
        (sw > 8'h01 && sw < 8'hff) |-> ip_addr[7:0] == sw && ip_gateway == 32'hc0a8_0101
            && ip_mask == 32'hffff_ff00;
    endproperty
    a_range_ip: assert property (p_range_ip) else $error("range address wrong");

    property p_nv;
        @(posedge pclk) disable iff (!presetn) use_nv_ip == (sw == 8'h00);
    endproperty
    a_nv: assert property (p_nv) else $error("nv select wrong");

    property p_bad;
        @(posedge pclk) disable iff (!presetn)
        sw_bad |-> !startup_ok && power_indicator_led == gateway_indicator_led;
    endproperty
    a_bad: assert property (p_bad) else $error("invalid switch not flagged");

    // Compared from the third edge after reset, so reset zeros are not taken for a sum
    property p_dip_sync;
        @(posedge pclk) disable iff (!presetn)
        (presetn && clk_en) ##1 clk_en |=> sw == ~$past(dip_switch_n, 2);
    endproperty
    a_dip_sync: assert property (p_dip_sync) else $error("switch sum wrong");

    // Bus answer and register read-back
    property p_apb_resp;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> pready && !pslverr;
    endproperty
    a_apb_resp: assert property (p_apb_resp) else $error("bus answer wrong");

    property p_id_read;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable && !pwrite && idx == gwc_pkg::IDX_SLAVE_ID)
        |=> prdata == {24'h00_0000, $past(master_slave_id)};
    endproperty
    a_id_read: assert property (p_id_read) else $error("id read-back wrong");

    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable && !pwrite && idx == gwc_pkg::IDX_STATUS)
        |=> prdata == {22'h00_0000, $past(sw_bad), $past(use_nv_ip), $past(sw)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // Refused, unmapped and frozen writes leave the settings alone
    property p_baud_drop;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_ok && idx == gwc_pkg::IDX_BAUD && wval > gwc_pkg::BAUD_MAX)
        |=> $stable(st_q.baud);
    endproperty
    a_baud_drop: assert property (p_baud_drop) else $error("illegal rate stored");

    property p_parity_drop;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_ok && idx == gwc_pkg::IDX_PARITY && wval > gwc_pkg::PARITY_MAX)
        |=> $stable(st_q.parity);
    endproperty
    a_parity_drop: assert property (p_parity_drop) else $error("illegal parity stored");

    property p_unmapped_wr;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_ok && (idx < gwc_pkg::IDX_SLAVE_ID || idx > gwc_pkg::IDX_PARITY))
        |=> $stable(st_q.slave_id) && $stable(st_q.baud) && $stable(st_q.parity);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write stored");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(st_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_id_bounds;
        @(posedge pclk) disable iff (!presetn)
        master_slave_id >= gwc_pkg::SLAVE_ID_MIN
            && master_slave_id <= gwc_pkg::SLAVE_ID_MAX;
    endproperty
    a_id_bounds: assert property (p_id_bounds) else $error("id out of range");

    // Line settings, start-up and led outputs, and address outputs
    property p_line_follow;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && frame_idle)
        |=> {6'h00, master_baud_sel} == $past(st_q.baud)
            && {6'h00, master_parity_sel} == $past(st_q.parity);
    endproperty
    a_line_follow: assert property (p_line_follow) else $error("line setting lags");

    property p_dark;
        @(posedge pclk) disable iff (!presetn)
        !sw_bad |-> startup_ok && !power_indicator_led && !gateway_indicator_led;
    endproperty
    a_dark: assert property (p_dark) else $error("leds lit on valid switch");

    property p_zero_addr;
        @(posedge pclk) disable iff (!presetn)
        (use_nv_ip || sw_bad) |-> ip_addr == 32'h0000_0000 && ip_mask == 32'h0000_0000
            && ip_gateway == 32'h0000_0000;
    endproperty
    a_zero_addr: assert property (p_zero_addr) else $error("address not cleared");

    // Main scenarios
    c_write_id: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ok && idx == gwc_pkg::IDX_SLAVE_ID);
    c_baud_apply: cover property (@(posedge pclk) disable iff (!presetn)
        $changed(master_baud_sel));
    c_bad_sw: cover property (@(posedge pclk) disable iff (!presetn) sw_bad);
    c_drop_id: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ok && idx == gwc_pkg::IDX_SLAVE_ID && wval > gwc_pkg::SLAVE_ID_MAX);
    c_frame_hold: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ok && idx == gwc_pkg::IDX_BAUD && !frame_idle);
endmodule : gwc_config

// *** hdl/gwc_pkg.sv ***
// Package of constants for the gateway serial and address configuration block
// Assumes a 32-bit APB register bus and a 10 MHz pclk
//
// What this block does
// - The gateway is the serial master and must use the same slave id, rate and parity as the slave.
// - Slave id entry 500 takes values 1 to 247 and resets to 2.
// - Baud entry 501 codes 0..3 as 9600..57600 bit/s, default 1; parity entry 502 codes none, odd, even, default 2.
// - Characters are always framed with exactly one stop bit, not configurable.
// - A legal write to a serial entry is stored at once, with no commit step; rate and parity reach the master only between frames.
// - An illegal value written to a serial entry is dropped and the old value kept.
// - The serial entries are volatile and return to defaults at every reset.
// - The block offers no means to change the slave's own serial settings.
// - The fieldbus address is the binary sum of the eight switch positions, 0 to 255.
// - Switch value 0 selects the stored nonvolatile IP settings.
// - Switch value 1 gives 192.168.1.1, mask 255.255.255.0, gateway 192.168.1.2.
// - Switch values 2 to 254 give 192.168.1.value, mask 255.255.255.0, gateway 192.168.1.1.
// - Switch value 255 is invalid: start-up halts and power and gateway leds flash red.
package gwc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_SLAVE_ID  = 12'h01f4;
    localparam logic [11:0] IDX_BAUD      = 12'h01f5;
    localparam logic [11:0] IDX_PARITY    = 12'h01f6;
    localparam logic [11:0] IDX_STATUS    = 12'h0200;
    localparam logic [11:0] IDX_IP_ADDR   = 12'h0201;
    localparam logic [11:0] IDX_IP_MASK   = 12'h0202;
    localparam logic [11:0] IDX_IP_GW     = 12'h0203;
    // ------------------------------------------------------------------
    // Reset values and ranges
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_SLAVE_ID  = 8'h02;
    localparam logic [7:0]  RST_BAUD      = 8'h01;
    localparam logic [7:0]  RST_PARITY    = 8'h02;
    localparam logic [7:0]  SLAVE_ID_MIN  = 8'h01;
    localparam logic [7:0]  SLAVE_ID_MAX  = 8'hf7;
    localparam logic [7:0]  BAUD_MAX      = 8'h03;
    localparam logic [7:0]  PARITY_MAX    = 8'h02;
    localparam logic [1:0]  STOP_BITS     = 2'h1;
    // ------------------------------------------------------------------
    // Address settings
    // ------------------------------------------------------------------
    localparam logic [23:0] IP_PREFIX     = 24'hc0_a801;
    localparam logic [31:0] IP_MASK       = 32'hffff_ff00;
    localparam logic [7:0]  SW_FIXED      = 8'h01;
    localparam logic [7:0]  SW_INVALID    = 8'hff;
    localparam logic [7:0]  GW_OCT_FIXED  = 8'h02;
    localparam logic [7:0]  GW_OCT_RANGE  = 8'h01;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          FLASH_MS      = 250;
    localparam int          FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
endpackage : gwc_pkg

// *** tb/gwc_serial_model.sv ***
// Serial engine stand-in that reports frame boundaries to the config block
// Assumes the pclk domain; a one-cycle start_frame pulse opens one frame
`timescale 1ns/100ps
module gwc_serial_model #(
    parameter int FRAME_CYC = 12
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Bench control
    input  wire logic start_frame,
    // To the config block
    output logic      frame_idle
);
    logic [7:0] left_q;

    // Count one frame down; idle only between frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            left_q <= 8'h00;
        else if (start_frame)
            left_q <= 8'(FRAME_CYC);
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end

    assign frame_idle = (left_q == 8'h00);
endmodule : gwc_serial_model

// *** tb/tb_top.sv ***
// Bench for the gateway config block: APB tasks and directed checks
// Assumes gwc_pkg, gwc_config and gwc_serial_model compiled before it
`timescale 1ns/100ps
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        en = 1'b1;
    logic        start_frame = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  dip_n = 8'hff;
    logic [31:0] prdata, ip_addr, ip_mask, ip_gw, q, ea, eg, em;
    logic [7:0]  sid, e, s;
    logic [1:0]  baud, par, stopb;
    logic        pready, pslverr, idle, nv, ok, led_p, led_g, bad;
    logic [7:0]  tv [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hf7, 8'hf8};
    logic [7:0]  lo [3] = '{8'h01, 8'h00, 8'h00};
    logic [7:0]  hi [3] = '{8'hf7, 8'h03, 8'h02};
    logic [7:0]  swv [5] = '{8'h00, 8'h01, 8'h28, 8'hfe, 8'hff};
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n, hi_n;

    // 10 MHz clock
    always #50 pclk = ~pclk;

    gwc_config #(.FLASH_CYC(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_idle(idle), .master_slave_id(sid), .master_baud_sel(baud),
        .master_parity_sel(par), .master_stop_bits(stopb), .dip_switch_n(dip_n),
        .use_nv_ip(nv), .ip_addr(ip_addr), .ip_mask(ip_mask), .ip_gateway(ip_gw),
        .startup_ok(ok), .power_indicator_led(led_p), .gateway_indicator_led(led_g));

    gwc_serial_model u_far (
        .pclk(pclk), .presetn(presetn), .start_frame(start_frame), .frame_idle(idle));

    // Verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        cmp_count++;
        if (g !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    // One APB transfer; read data lands in q
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        chk("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            error_cnt++;
            conclude();
        end
    endtask : apb

    task automatic rst_dflt;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 14'h07d0, '0);
        chk("slave_id", 32'h2, q);
        apb(1'b0, 14'h07d4, '0);
        chk("baud", 32'h1, q);
        apb(1'b0, 14'h07d8, '0);
        chk("parity", 32'h2, q);
        chk("stop_bits", 32'h1, {30'h0, stopb});
        $display("test defaults done");
    endtask : rst_dflt

    function automatic logic [7:0] outv(input int k);
        case (k)
            0: return sid;
            1: return {6'h0, baud};
            default: return {6'h0, par};
        endcase
    endfunction : outv

    initial begin
        rst_dflt();
        // Legal values apply, others are dropped
        for (int k = 0; k < 3; k++) begin
            e = outv(k);
            foreach (tv[i]) begin
                if (tv[i] >= lo[k] && tv[i] <= hi[k])
                    e = tv[i];
                apb(1'b1, 14'h07d0 + 14'(4 * k), {24'h0, tv[i]});
                repeat (2) @(posedge pclk);
                chk("setting", {24'h0, e}, {24'h0, outv(k)});
                apb(1'b0, 14'h07d0 + 14'(4 * k), '0);
                chk("readback", {24'h0, e}, q);
            end
        end
        $display("test ranges done");
        // Rate change waits for the frame boundary
        start_frame <= 1'b1;
        @(posedge pclk);
        start_frame <= 1'b0;
        apb(1'b1, 14'h07d4, '0);
        @(posedge pclk);
        chk("baud_in_frame", 32'h3, {30'h0, baud});
        n = 0;
        while (idle !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) begin
            error_cnt++;
            conclude();
        end
        repeat (2) @(posedge pclk);
        chk("baud_after_frame", 32'h0, {30'h0, baud});
        $display("test frame done");
        // Frozen clock enable holds the slave id setting
        en <= 1'b0;
        apb(1'b1, 14'h07d0, 32'h0000_0005);
        chk("id_frozen", 32'hf7, {24'h0, sid});
        en <= 1'b1;
        apb(1'b1, 14'h07d0, 32'h0000_0005);
        @(posedge pclk);
        chk("id_enabled", 32'h5, {24'h0, sid});
        $display("test enable done");
        // Switch decode
        foreach (swv[i]) begin
            s = swv[i];
            bad = (s == 8'hff);
            dip_n <= ~s;
            repeat (4) @(posedge pclk);
            chk("use_nv_ip", {31'h0, s == 8'h00}, {31'h0, nv});
            ea = (s == 0 || bad) ? '0 : {24'hc0_a801, s};
            eg = (s == 0 || bad) ? '0 : {24'hc0_a801, (s == 1) ? 8'h02 : 8'h01};
            em = (s == 0 || bad) ? '0 : 32'hffff_ff00;
            chk("ip_addr", ea, ip_addr);
            chk("ip_gw", eg, ip_gw);
            chk("ip_mask", em, ip_mask);
            chk("startup_ok", {31'h0, !bad}, {31'h0, ok});
            apb(1'b0, 14'h0800, '0);
            chk("status", {22'h0, bad, s == 8'h00, s}, q);
            apb(1'b0, 14'h0804, '0);
            chk("ip_addr_reg", ea, q);
            apb(1'b0, 14'h0808, '0);
            chk("ip_mask_reg", em, q);
            apb(1'b0, 14'h080c, '0);
            chk("ip_gw_reg", eg, q);
            hi_n = 0;
            repeat (12) begin
                @(posedge pclk);
                hi_n += (led_p === 1'b1);
                chk("led_pair", {31'h0, led_p}, {31'h0, led_g});
            end
            chk("led_flash", {31'h0, bad}, {31'h0, hi_n > 0 && hi_n < 12});
        end
        $display("test switches done");
        apb(1'b1, 14'h0400, 32'h0000_0009);
        apb(1'b0, 14'h0400, '0);
        chk("unmapped", '0, q);
        chk("id_kept", 32'h5, {24'h0, sid});
        rst_dflt();
        conclude();
    end
endmodule : tb_top
